// >>> common/adapt_frame_pkg.sv
// Constants shared by the header framer and the header parser.
// Assumes a byte stream carrying one LoWPAN frame per packet, marked by a last flag.
package adapt_frame_pkg;

  // ----------------------------------------------------------------
  // Dispatch values and header masks
  // ----------------------------------------------------------------
  localparam logic [7:0] MESH_DISPATCH = 8'h80;   // Mesh addressing header, top two bits 10.
  localparam logic [7:0] MESH_MASK = 8'hC0;
  localparam logic [7:0] BCAST_DISPATCH = 8'h50;  // Broadcast header.
  localparam logic [7:0] FRAG_DISPATCH = 8'hC0;   // First fragment, top five bits 11000.
  localparam logic [7:0] FRAG_MASK = 8'hF8;
  localparam logic [7:0] ESC_DISPATCH = 8'h7F;    // Escape dispatch for command frames.
  localparam logic [3:0] HOPS_FIELD_MAX = 4'hF;   // Mesh hops nibble is in bits 3:0 of the dispatch.

  // ----------------------------------------------------------------
  // Command identifiers
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_MESH_ROUTING = 8'h01;
  localparam logic [7:0] CMD_BOOTSTRAP = 8'h02;
  localparam logic [7:0] CMD_CONT_FREE = 8'h03;

  // ----------------------------------------------------------------
  // Hop limit and identifier handling
  // ----------------------------------------------------------------
  localparam logic [3:0] HOP_LIMIT_RESET = 4'h8;
  localparam logic [3:0] HOP_LIMIT_TOP = 4'hE;
  localparam logic [15:0] PAN_ID_MASK = 16'hFCFF;
  localparam logic [15:0] EUI_FILL = 16'hFFFE;    // Inserted between the two EUI-48 halves.
  localparam logic [7:0] UL_BIT_FLIP = 8'h02;     // Universal/local bit inverted for the identifier.

  // Header presence order index, lower value must come first.
  localparam logic [2:0] ORD_NONE = 3'h0;
  localparam logic [2:0] ORD_MESH = 3'h1;
  localparam logic [2:0] ORD_BCAST = 3'h2;
  localparam logic [2:0] ORD_FRAG = 3'h3;
  localparam logic [2:0] ORD_CMD = 3'h4;

  // True when the identifier is one of the defined commands.
  function automatic logic cmd_known(input logic [7:0] id);
    cmd_known = (id == CMD_MESH_ROUTING) || (id == CMD_BOOTSTRAP) || (id == CMD_CONT_FREE);
  endfunction : cmd_known

endpackage : adapt_frame_pkg

// >>> common/adapt_link_if.sv
// Byte stream link between the adaptation sublayer framer and the MAC-side parser.
// Assumes both ends share REF_CLK; the framer is the source of the stream.
`timescale 1ns/100ps
interface adapt_link_if;
  logic [7:0] data;  // Frame byte.
  logic valid;       // Byte offered.
  logic last;        // Final byte of the frame.
  logic ack_req;     // Acknowledgement request, held for the whole frame.
  logic ready;       // Receiver takes the byte.
  logic ack;         // One-cycle acknowledgement of a completed acked frame.

  modport framer (output data, output valid, output last, output ack_req, input ready, input ack);
  modport parser (input data, input valid, input last, input ack_req, output ready, output ack);
endinterface : adapt_link_if

// >>> hw/adapt_header_framer.sv
// Transmit end: builds the stacked adaptation headers ahead of the payload.
// Assumes a payload byte stream from the IP side and a MAC-side parser on the link.
//
// What this block does
// - Every data frame requests acknowledgement.
// - Non-beacon operation only, no beacon logic.
// - No prefix learning from router advertisements.
// - Headers ordered mesh, broadcast, fragment, command.
// - Hops remaining never above maximum hop limit.
// - Maximum hop limit 0..14, resets to eight.
// - Interface identifier from EUI-64 built from EUI-48.
// - Random PAN identifier ANDed with 0xFCFF.
// - Command frame is ESC then 8-bit identifier.
// - Command header placed after all other headers.
// - Command identifiers 01 routing, 02 bootstrap, 03 access.
`timescale 1ns/100ps
module adapt_header_framer
(
  input wire logic REF_CLK,                     // System clock, 100 MHz.
  input wire logic SRST,                        // Synchronous reset, active high.
  input wire logic HOP_LIMIT_WE,                // Writes HOP_LIMIT_IN to max_hop_limit.
  input wire logic [3:0] HOP_LIMIT_IN,          // New maximum hop limit.
  input wire logic [47:0] EUI48,                // Device EUI-48.
  input wire logic [15:0] PAN_ID_RAND,          // Randomly chosen PAN identifier.
  input wire logic START,                       // Pulse: begin a frame with the header set below.
  input wire logic USE_MESH,                    // Include mesh addressing header.
  input wire logic [3:0] HOPS_REQ,              // Requested hops remaining.
  input wire logic USE_BCAST,                   // Include broadcast header.
  input wire logic [7:0] BCAST_SEQ,             // Broadcast sequence number.
  input wire logic USE_FRAG,                    // Include first-fragment header.
  input wire logic [7:0] FRAG_SIZE,             // Low byte of datagram size.
  input wire logic USE_CMD,                     // Include command frame header.
  input wire logic [adapt_frame_pkg::ORD_CMD:0] UNUSED_PAD, // Reserved, ignored.
  input wire logic [7:0] CMD_ID,                // Command identifier.
  input wire logic [7:0] PAY_DATA,              // Payload byte.
  input wire logic PAY_VALID,                   // Payload byte offered.
  input wire logic PAY_LAST,                    // Final payload byte.
  output logic PAY_READY,                       // Payload byte taken.
  output logic BUSY,                            // Frame in progress.
  output logic ACKED,                           // Pulse: frame acknowledged.
  output logic [3:0] MAX_HOP_LIMIT,             // Current max_hop_limit.
  output logic [63:0] IFACE_ID,                 // Derived interface identifier.
  output logic [15:0] PAN_ID,                   // Masked PAN identifier.
  adapt_link_if.framer link                     // Link to the parser.
);
  import adapt_frame_pkg::*;

  typedef enum {S_IDLE, S_MESH, S_BCAST, S_BSEQ, S_FRAG, S_FSIZE, S_ESC, S_CMD, S_PAY} state_e;

  state_e state;
  state_e next_state;
  logic [3:0] hops;
  logic use_b, use_f, use_c;
  logic [7:0] seq, fsize, cmd;
  logic [7:0] buf_data [0:1];
  logic buf_last [0:1];
  logic [1:0] count;
  logic wr_ptr, rd_ptr;

  // ----------------------------------------------------------------
  // Configuration
  // ----------------------------------------------------------------

  // Hop limit only takes in-range values; out-of-range writes are ignored.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
      MAX_HOP_LIMIT <= HOP_LIMIT_RESET;
    else if (HOP_LIMIT_WE && HOP_LIMIT_IN <= HOP_LIMIT_TOP)
      MAX_HOP_LIMIT <= HOP_LIMIT_IN;
  end

  // Identifier outputs, built only from the hardware identifier and PAN_ID_RAND and never from a learned prefix.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      IFACE_ID <= 64'h0;
      PAN_ID <= 16'h0;
    end
    else
    begin
      IFACE_ID <= {EUI48[47:40] ^ UL_BIT_FLIP, EUI48[39:24], EUI_FILL, EUI48[23:0]};
      PAN_ID <= PAN_ID_RAND & PAN_ID_MASK;
    end
  end

  // ----------------------------------------------------------------
  // Header sequencer
  // ----------------------------------------------------------------
  wire buf_room = (count != 2'd2);
  wire emitting = (state != S_IDLE) && (state != S_PAY);
  wire pay_take = PAY_READY && PAY_VALID;
  wire [3:0] hops_clip = (HOPS_REQ > MAX_HOP_LIMIT) ? MAX_HOP_LIMIT : HOPS_REQ;

  // Header byte for the current state, in the fixed stacking order.
  wire [7:0] hdr_byte = (state == S_MESH) ? (MESH_DISPATCH | {4'h0, hops}) :
                        (state == S_BCAST) ? BCAST_DISPATCH :
                        (state == S_BSEQ) ? seq :
                        (state == S_FRAG) ? FRAG_DISPATCH :
                        (state == S_FSIZE) ? fsize :
                        (state == S_ESC) ? ESC_DISPATCH :
                        cmd;

  // Next state walks mesh, broadcast, fragment, command, payload.
  always_comb
  begin
    next_state = state;
    case (state)
      S_IDLE: if (START) next_state = USE_MESH ? S_MESH : USE_BCAST ? S_BCAST : USE_FRAG ? S_FRAG :
                                      USE_CMD ? S_ESC : S_PAY;
      S_MESH: if (buf_room) next_state = use_b ? S_BCAST : use_f ? S_FRAG : use_c ? S_ESC : S_PAY;
      S_BCAST: if (buf_room) next_state = S_BSEQ;
      S_BSEQ: if (buf_room) next_state = use_f ? S_FRAG : use_c ? S_ESC : S_PAY;
      S_FRAG: if (buf_room) next_state = S_FSIZE;
      S_FSIZE: if (buf_room) next_state = use_c ? S_ESC : S_PAY;
      S_ESC: if (buf_room) next_state = S_CMD;
      S_CMD: if (buf_room) next_state = S_PAY;
      S_PAY: if (pay_take && PAY_LAST) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  // State and captured header fields.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state <= S_IDLE;
      hops <= 4'h0;
      use_b <= 1'b0;
      use_f <= 1'b0;
      use_c <= 1'b0;
      seq <= 8'h00;
      fsize <= 8'h00;
      cmd <= 8'h00;
    end
    else
    begin
      state <= next_state;
      if (state == S_IDLE && START)
      begin
        hops <= hops_clip;
        use_b <= USE_BCAST;
        use_f <= USE_FRAG;
        use_c <= USE_CMD;
        seq <= BCAST_SEQ;
        fsize <= FRAG_SIZE;
        cmd <= CMD_ID;
      end
    end
  end

  // ----------------------------------------------------------------
  // Two-entry buffer toward the link
  // ----------------------------------------------------------------
  wire push = (emitting && buf_room) || pay_take;
  wire pop = link.ready && (count != 2'd0);
  wire [7:0] push_data = emitting ? hdr_byte : PAY_DATA;
  wire [1:0] next_count = count + {1'b0, push} - {1'b0, pop};

  // Stores pushed bytes; a stalled parser fills it and stalls the sequencer.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      count <= 2'd0;
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
    end
    else
    begin
      count <= next_count;
      if (push)
      begin
        buf_data[wr_ptr] <= push_data;
        buf_last[wr_ptr] <= pay_take && PAY_LAST;
        wr_ptr <= ~wr_ptr;
      end
      if (pop)
        rd_ptr <= ~rd_ptr;
    end
  end

  assign link.data = buf_data[rd_ptr];
  assign link.valid = (count != 2'd0);
  assign link.last = buf_last[rd_ptr] && (count != 2'd0);
  assign link.ack_req = 1'b1;

  // Status outputs and payload ready, the latter from next state and fill so it matches the live condition.
  // Beaconless operation needs no superframe tracking here.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      BUSY <= 1'b0;
      ACKED <= 1'b0;
      PAY_READY <= 1'b0;
    end
    else
    begin
      BUSY <= (next_state != S_IDLE) || (count != 2'd0);
      ACKED <= link.ack;
      PAY_READY <= (next_state == S_PAY) && (next_count != 2'h2);
    end
  end

endmodule : adapt_header_framer

// >>> hw/adapt_header_parser.sv
// Receive end: strips and checks the stacked adaptation headers.
// Assumes the framer on the link; delivers header fields and payload upward.
`timescale 1ns/100ps
module adapt_header_parser
(
  input wire logic REF_CLK,          // System clock, 100 MHz.
  input wire logic SRST,             // Synchronous reset, active high.
  adapt_link_if.parser link,         // Link from the framer.
  output logic [7:0] UP_DATA,        // Payload byte upward.
  output logic UP_VALID,             // Pulse: payload byte valid.
  output logic UP_LAST,              // Final payload byte.
  output logic [3:0] HOPS_SEEN,      // Hops remaining of last mesh header.
  output logic [7:0] CMD_SEEN,       // Command identifier of accepted frame.
  output logic CMD_FRAME,            // Current frame is a command frame.
  output logic DROPPED               // Pulse: frame discarded.
);
  import adapt_frame_pkg::*;

  typedef enum {P_HDR, P_BSEQ, P_FSIZE, P_CMD, P_PAY, P_DROP} pstate_e;

  pstate_e state;
  pstate_e next_state;
  logic [2:0] last_ord;

  wire take = link.valid;
  wire [7:0] b = link.data;
  wire is_mesh = (b & MESH_MASK) == MESH_DISPATCH;
  wire is_frag = (b & FRAG_MASK) == FRAG_DISPATCH;
  wire is_bcast = (b == BCAST_DISPATCH);
  wire is_esc = (b == ESC_DISPATCH);
  wire [2:0] ord = is_mesh ? ORD_MESH : is_bcast ? ORD_BCAST : is_frag ? ORD_FRAG : is_esc ? ORD_CMD : ORD_NONE;
  wire out_of_order = (ord != ORD_NONE) && (ord <= last_ord);

  // ----------------------------------------------------------------
  // Header walker
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      P_HDR: next_state = out_of_order ? P_DROP : is_bcast ? P_BSEQ : is_frag ? P_FSIZE :
                          is_esc ? P_CMD : is_mesh ? P_HDR : P_PAY;
      P_BSEQ: next_state = P_HDR;
      P_FSIZE: next_state = P_HDR;
      P_CMD: next_state = cmd_known(b) ? P_PAY : P_DROP;
      P_PAY: next_state = P_PAY;
      P_DROP: next_state = P_DROP;
      default: next_state = P_HDR;
    endcase
    if (take && link.last)
      next_state = P_HDR;
  end

  assign link.ready = 1'b1;

  // State, order tracking and upward outputs.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      state <= P_HDR;
      last_ord <= ORD_NONE;
      link.ack <= 1'b0;
      UP_DATA <= 8'h00;
      UP_VALID <= 1'b0;
      UP_LAST <= 1'b0;
      HOPS_SEEN <= 4'h0;
      CMD_SEEN <= 8'h00;
      CMD_FRAME <= 1'b0;
      DROPPED <= 1'b0;
    end
    else
    begin
      link.ack <= 1'b0;
      UP_VALID <= 1'b0;
      DROPPED <= 1'b0;
      if (take)
      begin
        state <= next_state;
        if (state == P_HDR && ord != ORD_NONE)
          last_ord <= ord;
        if (state == P_HDR && is_mesh)
          HOPS_SEEN <= b[3:0] & HOPS_FIELD_MAX;
        if (state == P_HDR)
          CMD_FRAME <= is_esc;
        if (state == P_CMD && cmd_known(b))
          CMD_SEEN <= b;
        // Payload, or the first non-header byte, passes upward.
        if (state == P_PAY || (state == P_HDR && ord == ORD_NONE))
        begin
          UP_DATA <= b;
          UP_VALID <= 1'b1;
          UP_LAST <= link.last;
        end
        if (next_state == P_DROP && state != P_DROP)
          DROPPED <= 1'b1;
        if (link.last)
        begin
          last_ord <= ORD_NONE;
          link.ack <= link.ack_req;
        end
      end
    end
  end

endmodule : adapt_header_parser

// >>> tb/adapt_link_chk.sv
// Concurrent checks on the link between the header framer and the parser.
// Assumes the link signals as plain inputs and the shared clock and reset.
`timescale 1ns/100ps
module adapt_link_chk
(
  input wire logic REF_CLK,     // System clock.
  input wire logic SRST,        // Synchronous reset, active high.
  input wire logic [7:0] data,  // Frame byte.
  input wire logic valid,       // Byte offered.
  input wire logic last,        // Final byte of the frame.
  input wire logic ack_req,     // Acknowledgement request.
  input wire logic ready,       // Receiver takes the byte.
  input wire logic ack          // Acknowledgement pulse.
);
  import adapt_frame_pkg::*;
  logic in_hdr;
  logic skip;
  logic [2:0] last_ord;
  wire [2:0] ord = ((data & MESH_MASK) == MESH_DISPATCH) ? ORD_MESH : (data == BCAST_DISPATCH) ? ORD_BCAST :
                   ((data & FRAG_MASK) == FRAG_DISPATCH) ? ORD_FRAG : (data == ESC_DISPATCH) ? ORD_CMD : ORD_NONE;
  wire at_disp = valid && in_hdr && !skip;
  wire last_byte = valid && last;

  // --------------------------------------------------------------
  // Header tracking
  // --------------------------------------------------------------
  // Follows the header stack; the second byte of a two-byte header is skipped.
  always_ff @(posedge REF_CLK)
  begin
    if (SRST)
    begin
      in_hdr <= 1'b1;
      skip <= 1'b0;
      last_ord <= ORD_NONE;
    end
    else if (valid)
    begin
      in_hdr <= last | (in_hdr & (skip | (ord != ORD_NONE)));
      skip <= at_disp && (ord > ORD_MESH);
      last_ord <= last ? ORD_NONE : (at_disp && ord != ORD_NONE) ? ord : last_ord;
    end
  end

  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (SRST);

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  // Every byte sent asks for an acknowledgement, and the receiver answers.
  chk_ack_req_held: assert property (valid |-> ack_req)
    else $error("byte sent without acknowledgement request");
  chk_ack_after_last: assert property (last_byte |=> ack)
    else $error("frame end not acknowledged next cycle");
  chk_ack_has_cause: assert property (ack |-> $past(last_byte))
    else $error("acknowledgement without a frame end");
  chk_rx_ready: assert property (valid |-> ready)
    else $error("receiver not ready for a byte");
  // Header order and shape.
  chk_header_order: assert property (at_disp && ord != ORD_NONE |-> ord > last_ord)
    else $error("adaptation headers out of order");
  chk_hops_bound: assert property (at_disp && ord == ORD_MESH |-> data[3:0] <= HOP_LIMIT_TOP)
    else $error("hops remaining above the hop limit range");
  chk_cmd_id: assert property (valid && skip && last_ord == ORD_CMD |->
    data >= CMD_MESH_ROUTING && data <= CMD_CONT_FREE)
    else $error("undefined command identifier after escape");
  chk_header_whole: assert property (at_disp && ord > ORD_MESH |-> !last)
    else $error("two-byte header cut short by frame end");
endmodule : adapt_link_chk

// >>> tb/test_adaptation_header_framer.sv
// Self-checking bench: framer and parser back to back, and a parser fed by hand.
// Assumes the package and the link interface are compiled before this file.
`timescale 1ns/100ps
module test_adaptation_header_framer;
  import adapt_frame_pkg::*;
  `define CHECK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: %h %h", $time, a, b); end end
  logic ref_clk = 0, srst = 1, hop_we = 0, start = 0, use_mesh = 0, use_bcast = 0, use_frag = 0, use_cmd = 0;
  logic pay_valid = 0, pay_last = 0;
  logic [3:0] hop_in = 0, hops_req = 0, exp_max = HOP_LIMIT_RESET;
  logic [7:0] bcast_seq = 0, frag_size = 0, cmd_id = 0, pay_data = 0;
  logic [47:0] eui48 = 0;
  logic [15:0] pan_rand = 0;
  logic pay_ready, busy, acked, up_valid, up_last, cmd_frame, dropped, up_valid2, dropped2;
  logic [3:0] max_hop, hops_seen;
  logic [63:0] iface_id;
  logic [15:0] pan_id;
  logic [7:0] up_data, cmd_seen, cmd_seen2;
  logic [31:0] rnd = 32'h00015B19;
  logic [7:0] got[$], sent[$], ids[3] = '{CMD_MESH_ROUTING, CMD_BOOTSTRAP, CMD_CONT_FREE}, limits[4] = '{15, 14, 0, 5};
  int bad_count = 0, checked = 0, acks = 0, acks2 = 0, drops = 0, drops2 = 0, ups2 = 0;
  adapt_link_if link();
  adapt_link_if link2();

  always #5 ref_clk = ~ref_clk;
  initial
  begin
    link2.data = 8'h00;
    link2.valid = 1'b0;
    link2.last = 1'b0;
    link2.ack_req = 1'b1;
  end

  adapt_header_framer adapt_header_framer_inst (.REF_CLK(ref_clk), .SRST(srst), .HOP_LIMIT_WE(hop_we),
    .HOP_LIMIT_IN(hop_in), .EUI48(eui48), .PAN_ID_RAND(pan_rand), .START(start), .USE_MESH(use_mesh),
    .HOPS_REQ(hops_req), .USE_BCAST(use_bcast), .BCAST_SEQ(bcast_seq), .USE_FRAG(use_frag), .FRAG_SIZE(frag_size),
    .USE_CMD(use_cmd), .UNUSED_PAD('0), .CMD_ID(cmd_id), .PAY_DATA(pay_data), .PAY_VALID(pay_valid),
    .PAY_LAST(pay_last), .PAY_READY(pay_ready), .BUSY(busy), .ACKED(acked), .MAX_HOP_LIMIT(max_hop),
    .IFACE_ID(iface_id), .PAN_ID(pan_id), .link(link));
  adapt_header_parser adapt_header_parser_inst (.REF_CLK(ref_clk), .SRST(srst), .link(link), .UP_DATA(up_data),
    .UP_VALID(up_valid), .UP_LAST(up_last), .HOPS_SEEN(hops_seen), .CMD_SEEN(cmd_seen), .CMD_FRAME(cmd_frame),
    .DROPPED(dropped));
  adapt_header_parser adapt_header_parser_inst2 (.REF_CLK(ref_clk), .SRST(srst), .link(link2), .UP_DATA(),
    .UP_VALID(up_valid2), .UP_LAST(), .HOPS_SEEN(), .CMD_SEEN(cmd_seen2), .CMD_FRAME(), .DROPPED(dropped2));
  adapt_link_chk adapt_link_chk_inst (.REF_CLK(ref_clk), .SRST(srst), .data(link.data), .valid(link.valid),
    .last(link.last), .ack_req(link.ack_req), .ready(link.ready), .ack(link.ack));

  // Collects payload bytes and counts the pulses of both parsers.
  always @(posedge ref_clk)
  begin
    if (up_valid === 1'b1) got.push_back(up_data);
    if (acked === 1'b1) acks++;
    if (dropped === 1'b1) drops++;
    if (dropped2 === 1'b1) drops2++;
    if (up_valid2 === 1'b1) ups2++;
    if (link2.ack === 1'b1) acks2++;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h00400007 : 32'h00000000);
  endfunction : lfsr

  task automatic end_sim();
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim

  // Runs one frame through the framer and compares what the parser delivers.
  task automatic send_frame(input int len);
    int n;
    int a;
    int d;
    sent.delete();
    got.delete();
    n = 0;
    while (busy !== 1'b0 && n++ < 100) @(posedge ref_clk);
    a = acks;
    d = drops;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    for (int i = 0; i < len; i++)
    begin
      rnd = lfsr(rnd);
      pay_data <= rnd[7:0] & 8'h3F;
      sent.push_back(rnd[7:0] & 8'h3F);
      pay_valid <= 1'b1;
      pay_last <= (i == len - 1);
      n = 0;
      do @(posedge ref_clk); while (pay_ready !== 1'b1 && ++n < 100);
    end
    pay_valid <= 1'b0;
    pay_last <= 1'b0;
    n = 0;
    while (acks == a && n++ < 100) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
    `CHECK(acks, a + 1)
    `CHECK(drops, d)
    `CHECK(got.size(), sent.size())
    foreach (sent[i]) `CHECK(got[i], sent[i])
    if (use_mesh) `CHECK(hops_seen, (hops_req > exp_max) ? exp_max : hops_req)
    if (use_cmd) `CHECK(cmd_seen, cmd_id)
    `CHECK(iface_id, {eui48[47:40] ^ UL_BIT_FLIP, eui48[39:24], EUI_FILL, eui48[23:0]})
    `CHECK(pan_id, pan_rand & PAN_ID_MASK)
    `CHECK(cmd_frame, use_cmd)
    `CHECK(up_last, 1'b1)
    `CHECK(busy, 1'b0)
  endtask : send_frame

  // Drives the second link by hand, then checks drop, delivery and acknowledgement.
  task automatic raw_frame(input logic [7:0] b[$], input int drop);
    int a;
    int d;
    int u;
    a = acks2;
    d = drops2;
    u = ups2;
    foreach (b[i])
    begin
      link2.data <= b[i];
      link2.valid <= 1'b1;
      link2.last <= (i == b.size() - 1);
      @(posedge ref_clk);
    end
    link2.valid <= 1'b0;
    link2.last <= 1'b0;
    link2.data <= ~b[b.size() - 1];
    repeat (4) @(posedge ref_clk);
    `CHECK(acks2, a + 1)
    `CHECK(drops2, d + drop)
    `CHECK(ups2, drop ? u : u + 1)
  endtask : raw_frame

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    `CHECK(max_hop, HOP_LIMIT_RESET)
    foreach (limits[k])
    begin
      hop_in <= limits[k][3:0];
      hop_we <= 1'b1;
      @(posedge ref_clk);
      hop_we <= 1'b0;
      @(posedge ref_clk);
      if (limits[k] <= HOP_LIMIT_TOP) exp_max = limits[k][3:0];
      `CHECK(max_hop, exp_max)
      for (int f = 0; f < 8; f++)
      begin
        rnd = lfsr(rnd);
        {use_mesh, use_bcast, use_frag, use_cmd} <= (f == 0) ? 4'hF : rnd[3:0];
        hops_req <= (f == 0) ? 4'hF : rnd[11:8];
        bcast_seq <= rnd[23:16];
        frag_size <= rnd[31:24];
        cmd_id <= ids[f % 3];
        eui48 <= {rnd, rnd[15:0] ^ 16'hA5C3};
        pan_rand <= rnd[31:16];
        send_frame(1 + rnd[13:12]);
      end
    end
    raw_frame('{FRAG_DISPATCH, 8'h10, MESH_DISPATCH | 8'h01, 8'h05}, 1);
    raw_frame('{BCAST_DISPATCH, 8'h07, ESC_DISPATCH, CMD_BOOTSTRAP, 8'h05}, 0);
    raw_frame('{ESC_DISPATCH, 8'h00, 8'h21}, 1);
    raw_frame('{ESC_DISPATCH, 8'h04, 8'h21}, 1);
    foreach (ids[k])
    begin
      raw_frame('{ESC_DISPATCH, ids[k], 8'h21}, 0);
      `CHECK(cmd_seen2, ids[k])
    end
    end_sim();
  end

  // Cuts a hang short well after the expected run of under a thousand cycles.
  initial
  begin
    #200000;
    bad_count++;
    end_sim();
  end
endmodule : test_adaptation_header_framer
